// file: logic/iss_map.vh
`ifndef ISS_MAP_VH
`define ISS_MAP_VH

// Register byte addresses (even byte of each word)
`define ISS_ADDR_FILT 7'h5C
`define ISS_ADDR_RANGE 7'h5E
`define ISS_ADDR_MSC 7'h60
`define ISS_ADDR_SCALE 7'h62
`define ISS_ADDR_DEC 7'h64

// Reset values
`define ISS_RST_FILT 3'h0
`define ISS_RST_MSC 8'hC1
`define ISS_RST_SCALE 16'h07D0
`define ISS_RST_DEC 11'h000

// Field positions
`define ISS_MSC_LING 7
`define ISS_MSC_POP 6
`define ISS_MSC_RSVD 5
`define ISS_MSC_MODE_HI 4
`define ISS_MSC_MODE_LO 2
`define ISS_MSC_SPOL 1
`define ISS_MSC_DPOL 0
`define ISS_RANGE_LOW 2'h3
`define ISS_DEC_W 11

// Sync function codes
`define ISS_MODE_INT 3'h0
`define ISS_MODE_DIRECT 3'h1
`define ISS_MODE_SCALED 3'h2
`define ISS_MODE_OUTSYNC 3'h3
`define ISS_MODE_PULSE 3'h5

// Serial word layout
`define ISS_WORD_BITS 5'h10
`define ISS_WORD_WR 15

// Timing
`define ISS_CLK_HZ 25000000
`define ISS_INT_RATE_HZ 2000
`define ISS_ACC_RATE_HZ 4000
`define ISS_PULSE_CYC 16'h0019

`endif

// file: logic/iss_sync.v
`timescale 1ns/100ps
module iss_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Asynchronous levels in
  input wire [W-1:0] async_in,
  // Synchronised level and its previous value
  output reg [W-1:0] level,
  output reg [W-1:0] level_prev
);

  reg [W-1:0] meta_q;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= RST_VAL;
      level <= RST_VAL;
      level_prev <= RST_VAL;
    end else begin
      meta_q <= async_in;
      level <= meta_q;
      level_prev <= level;
    end
  end

endmodule

// file: logic/iss_top.v
`timescale 1ns/100ps
`include "iss_map.vh"

// Functional notes
// - Two averaging stages, each 2^B taps
// - Filter phase delay equals N samples
// - Read-only range code, low bits read 11
// - Bit 7 enables gyro linear-g compensation
// - Bit 6 enables accel point-of-percussion alignment
// - Bits 4:2 select clock source
// - Bit 1 selects active sync edge
// - Bit 0 sets data-ready pin polarity
// - Internal mode: 2000 Hz, accel 4000 Hz pairs
// - Output sync: internal plus sync pulses
// - Direct: gyro one edge, accel both averaged
// - Pulse: accel on leading edge, 370 Hz
// - Scaled mode accepts 1 to 128 Hz
// - Scaled sample rate is sync times factor
// - Decimation 11 bits, max 1999 (logic accepts up to 2047), top ignored
// - Output rate is sample rate over dec+1
// - Scaled uses factor; direct, pulse use one
module iss_top #(
  parameter GYRO_RANGE = 2'h3,
  parameter INT_PERIOD = `ISS_CLK_HZ / `ISS_INT_RATE_HZ,
  parameter ACC_PERIOD = `ISS_CLK_HZ / `ISS_ACC_RATE_HZ,
  parameter PULSE_CYC = `ISS_PULSE_CYC
) (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Serial register port
  input wire sclk,
  input wire cs_n,
  input wire din,
  output reg dout,
  // Sync pin
  input wire sync_in,
  output reg sync_out,
  output reg sync_oe,
  // Data-ready pin
  output reg data_valid_pin,
  // Sample timing to the datapath
  output reg sample_clock_rate,
  output reg accel_sample,
  output reg accel_update,
  output reg output_update,
  // Datapath configuration
  output reg [7:0] filt_taps,
  output reg [7:0] filt_delay,
  output reg lin_g_comp_en,
  output reg pop_align_en,
  output reg bw_limit_en
);

  // Counter limits and pulse width
  localparam [15:0] ACC_LAST = ACC_PERIOD[15:0] - 16'h0001;
  localparam [15:0] PULSE_LOAD = PULSE_CYC[15:0];
  localparam [25:0] PER_ONE = 26'h0000001;
  localparam [25:0] PER_SAT = 26'h3FFFFFF;

  // Synchronised pins
  wire sclk_s;
  wire cs_n_s;
  wire din_s;
  wire sync_s;
  wire sclk_p;
  wire cs_n_p;
  wire din_p;
  wire sync_p;

  // Pins idle with sclk low, cs_n high, din low and sync low
  // Reset to those levels so no false edge follows reset
  iss_sync #(.W(4), .RST_VAL(4'h4)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({sclk, cs_n, din, sync_in}),
    .level({sclk_s, cs_n_s, din_s, sync_s}),
    .level_prev({sclk_p, cs_n_p, din_p, sync_p})
  );

  // Serial port state
  reg [15:0] shift_q;
  reg [15:0] tx_q;
  reg [15:0] rd_q;
  reg [4:0] bitcnt_q;
  reg [15:0] rd_mux;

  // Registers
  reg [2:0] filt_q;
  reg [7:0] msc_q;
  reg [15:0] scale_q;
  reg [10:0] dec_q;

  wire sclk_rise = sclk_s & ~sclk_p;
  wire sclk_fall = ~sclk_s & sclk_p;
  wire cs_fall = ~cs_n_s & cs_n_p;
  wire cs_rise = cs_n_s & ~cs_n_p;
  wire word_done = cs_rise && (bitcnt_q == `ISS_WORD_BITS);
  wire wr_en = word_done & shift_q[`ISS_WORD_WR];
  wire [6:0] wr_addr = shift_q[14:8];
  wire [7:0] wr_data = shift_q[7:0];
  wire [6:0] wr_word = {wr_addr[6:1], 1'b0};
  wire wr_hi = wr_addr[0];

  // Read word chosen by the address of the word just received
  // Address bit 0 (word bit 8) is ignored so either byte address reads the word
  always @* begin
    case ({shift_q[14:9], 1'b0})
      `ISS_ADDR_FILT: rd_mux = {13'h0000, filt_q};
      `ISS_ADDR_RANGE: rd_mux = {12'h000, GYRO_RANGE[1:0], `ISS_RANGE_LOW};
      `ISS_ADDR_MSC: rd_mux = {8'h00, msc_q};
      `ISS_ADDR_SCALE: rd_mux = scale_q;
      `ISS_ADDR_DEC: rd_mux = {5'h00, dec_q};
      default: rd_mux = 16'h0000;
    endcase
  end

  // Serial word capture and read-back
  // Bit count saturates, so an overlong frame keeps its last 16 bits
  // Read data is shown in the frame after the request
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_q <= 16'h0000;
      tx_q <= 16'h0000;
      rd_q <= 16'h0000;
      bitcnt_q <= 5'h00;
      dout <= 1'b0;
    end else begin
      if (cs_fall) begin
        bitcnt_q <= 5'h00;
        dout <= rd_q[15];
        tx_q <= {rd_q[14:0], 1'b0};
      end else if (!cs_n_s && sclk_rise) begin
        shift_q <= {shift_q[14:0], din_s};
        if (bitcnt_q != `ISS_WORD_BITS) begin
          bitcnt_q <= bitcnt_q + 5'h01;
        end
      end else if (!cs_n_s && sclk_fall) begin
        dout <= tx_q[15];
        tx_q <= {tx_q[14:0], 1'b0};
      end
      if (word_done && !shift_q[`ISS_WORD_WR]) begin
        rd_q <= rd_mux;
      end
    end
  end

  // Register writes, one byte per word
  // Read-only and unmapped addresses fall through and are ignored
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      filt_q <= `ISS_RST_FILT;
      msc_q <= `ISS_RST_MSC;
      scale_q <= `ISS_RST_SCALE;
      dec_q <= `ISS_RST_DEC;
    end else if (wr_en) begin
      case (wr_word)
        `ISS_ADDR_FILT: begin
          if (!wr_hi) begin
            filt_q <= wr_data[2:0];
          end
        end
        `ISS_ADDR_MSC: begin
          if (!wr_hi) begin
            msc_q <= wr_data & ~(8'h01 << `ISS_MSC_RSVD);
          end
        end
        `ISS_ADDR_SCALE: begin
          if (wr_hi) begin
            scale_q[15:8] <= wr_data;
          end else begin
            scale_q[7:0] <= wr_data;
          end
        end
        `ISS_ADDR_DEC: begin
          if (wr_hi) begin
            dec_q[10:8] <= wr_data[2:0];
          end else begin
            dec_q[7:0] <= wr_data;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Clock source decode
  // Codes 100, 110 and 111 run as internal mode
  wire [2:0] mode = msc_q[`ISS_MSC_MODE_HI:`ISS_MSC_MODE_LO];
  wire m_direct = (mode == `ISS_MODE_DIRECT);
  wire m_scaled = (mode == `ISS_MODE_SCALED);
  wire m_pulse = (mode == `ISS_MODE_PULSE);
  wire m_out = (mode == `ISS_MODE_OUTSYNC);
  wire m_int = ~(m_direct | m_scaled | m_pulse);
  wire spol = msc_q[`ISS_MSC_SPOL];
  wire dpol = msc_q[`ISS_MSC_DPOL];

  wire sync_rise = sync_s & ~sync_p;
  wire sync_fall = ~sync_s & sync_p;
  wire act_edge = spol ? sync_rise : sync_fall;
  wire oth_edge = spol ? sync_fall : sync_rise;

  // Internal 4000 Hz accel timer, every second tick is the 2000 Hz sample
  reg [15:0] acc_cnt_q;
  reg half_q;
  wire acc_tick = m_int && (acc_cnt_q == ACC_LAST);

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_cnt_q <= 16'h0000;
      half_q <= 1'b0;
    end else if (!m_int) begin
      acc_cnt_q <= 16'h0000;
      half_q <= 1'b0;
    end else if (acc_tick) begin
      acc_cnt_q <= 16'h0000;
      half_q <= ~half_q;
    end else begin
      acc_cnt_q <= acc_cnt_q + 16'h0001;
    end
  end

  wire int_tick = acc_tick & half_q;

  // Scaled mode: measure the sync period, add the factor each cycle
  // Period is latched on each active edge; no tick until the first edge,
  // whose latched count runs from entry to scaled mode
  // Remainder carries over so the long-run rate stays exact
  reg [25:0] per_cnt_q;
  reg [25:0] per_q;
  reg [25:0] ph_q;
  wire [26:0] ph_sum = {1'b0, ph_q} + {11'h000, scale_q};
  wire scl_tick = m_scaled && (per_q != 26'h0000000) && (ph_sum >= {1'b0, per_q});

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      per_cnt_q <= 26'h0000000;
      per_q <= 26'h0000000;
      ph_q <= 26'h0000000;
    end else if (!m_scaled) begin
      per_cnt_q <= 26'h0000000;
      per_q <= 26'h0000000;
      ph_q <= 26'h0000000;
    end else begin
      if (act_edge) begin
        per_cnt_q <= PER_ONE;
        per_q <= per_cnt_q;
      end else if (per_cnt_q != PER_SAT) begin
        per_cnt_q <= per_cnt_q + 26'h0000001;
      end
      if (per_q == 26'h0000000) begin
        ph_q <= 26'h0000000;
      end else if (scl_tick) begin
        ph_q <= ph_sum[25:0] - per_q;
      end else begin
        ph_q <= ph_sum[25:0];
      end
    end
  end

  // Sample strobes by source
  wire ext_edge = (m_direct | m_pulse) & act_edge;
  wire smp_tick = int_tick | ext_edge | scl_tick;
  wire acc_smp = acc_tick | ext_edge | (m_direct & oth_edge) | scl_tick;
  wire acc_upd = int_tick | (m_direct & oth_edge) | (m_pulse & act_edge) | scl_tick;

  // Decimation
  // Greater-or-equal compare lets a lowered decimation value (a raised output rate) take effect at once
  reg [10:0] dec_cnt_q;
  wire dec_hit = smp_tick && (dec_cnt_q >= dec_q);

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dec_cnt_q <= 11'h000;
    end else if (dec_hit) begin
      dec_cnt_q <= 11'h000;
    end else if (smp_tick) begin
      dec_cnt_q <= dec_cnt_q + 11'h001;
    end
  end

  // Pin pulse timers
  // Fixed width pulses so a slow host still sees them
  reg [15:0] dr_cnt_q;
  reg [15:0] so_cnt_q;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dr_cnt_q <= 16'h0000;
      so_cnt_q <= 16'h0000;
    end else begin
      if (dec_hit) begin
        dr_cnt_q <= PULSE_LOAD;
      end else if (dr_cnt_q != 16'h0000) begin
        dr_cnt_q <= dr_cnt_q - 16'h0001;
      end
      if (m_out && int_tick) begin
        so_cnt_q <= PULSE_LOAD;
      end else if (so_cnt_q != 16'h0000) begin
        so_cnt_q <= so_cnt_q - 16'h0001;
      end
    end
  end

  // Registered outputs
  // Pin levels are the active flag folded with the polarity bit
  // Data-ready follows output_update by one cycle
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_valid_pin <= 1'b0;
      sync_out <= 1'b0;
      sync_oe <= 1'b0;
      sample_clock_rate <= 1'b0;
      accel_sample <= 1'b0;
      accel_update <= 1'b0;
      output_update <= 1'b0;
      filt_taps <= 8'h01;
      filt_delay <= 8'h01;
      lin_g_comp_en <= 1'b1;
      pop_align_en <= 1'b1;
      bw_limit_en <= 1'b0;
    end else begin
      data_valid_pin <= (dr_cnt_q != 16'h0000) ~^ dpol;
      sync_out <= (so_cnt_q != 16'h0000) ~^ spol;
      sync_oe <= m_out;
      sample_clock_rate <= smp_tick;
      accel_sample <= acc_smp;
      accel_update <= acc_upd;
      output_update <= dec_hit;
      filt_taps <= 8'h01 << filt_q;
      filt_delay <= 8'h01 << filt_q;
      lin_g_comp_en <= msc_q[`ISS_MSC_LING];
      pop_align_en <= msc_q[`ISS_MSC_POP];
      bw_limit_en <= m_pulse;
    end
  end

endmodule

// file: verif/iss_top_asserts.sv
`timescale 1ns/100ps
module iss_top_asserts (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Sync pin
  input wire sync_out,
  input wire sync_oe,
  // Data-ready and strobes
  input wire data_valid_pin,
  input wire sample_clock_rate,
  input wire output_update,
  // Configuration
  input wire [7:0] filt_taps,
  input wire [7:0] filt_delay,
  input wire bw_limit_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_taps_delay_eq: assert property (filt_delay == filt_taps)
    else $error("filter delay differs from tap count");
  a_taps_power_two: assert property ($onehot(filt_taps))
    else $error("tap count is not a power of two");
  a_oe_bw_exclusive: assert property (!(sync_oe && bw_limit_en))
    else $error("output sync and pulse mode at once");
  a_update_on_sample: assert property (output_update |-> sample_clock_rate)
    else $error("output update without a sample tick");
  a_update_spacing: assert property (output_update |=> !output_update [*8])
    else $error("output updates too close");
  a_ready_pulse_hold: assert property (output_update |=> $changed(data_valid_pin) ##1
    $stable(data_valid_pin) [*8])
    else $error("data ready pulse wrong");
  a_sync_pulse_hold: assert property (sync_oe && $changed(sync_out) |=>
    $stable(sync_out) [*8])
    else $error("sync output pulse too short");
  a_sync_on_tick: assert property (sync_oe && sample_clock_rate |->
    ##[0:2] $changed(sync_out))
    else $error("no sync output pulse at sample tick");
  c_update: cover property (output_update);
  c_sync_out: cover property (sync_oe && sample_clock_rate);
  c_pulse_mode: cover property (bw_limit_en && sample_clock_rate);
endmodule

bind iss_top iss_top_asserts u_chk (.clk(clk), .reset_n(reset_n), .sync_out(sync_out),
  .sync_oe(sync_oe), .data_valid_pin(data_valid_pin), .sample_clock_rate(sample_clock_rate),
  .output_update(output_update), .filt_taps(filt_taps), .filt_delay(filt_delay),
  .bw_limit_en(bw_limit_en));

// file: verif/iss_host_model.sv
`timescale 1ns/100ps
module iss_host_model (
  // Clock
  input wire clk,
  // Serial port
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire dout,
  // Sync source
  output logic sync_src
);
  int hi_cyc = 0;
  int lo_cyc = 0;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
    sync_src = 1'b0;
  end
  // Idle low while no period set
  always begin
    if (hi_cyc == 0) begin
      @(posedge clk);
    end else begin
      repeat (lo_cyc) @(posedge clk);
      sync_src <= 1'b1;
      repeat (hi_cyc) @(posedge clk);
      sync_src <= 1'b0;
    end
  end
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    @(posedge clk) cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      repeat (4) @(posedge clk);
      din <= w[i];
      repeat (4) @(posedge clk);
      r[i] = dout;
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
endmodule

// file: verif/tb_iss_top.sv
`timescale 1ns/100ps
`include "iss_map.vh"
module tb_iss_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [31:0] seed = 32'h0000B6B6;
  wire sclk, cs_n, din, dout, sync_src, sync_out, sync_oe, dvp, scr, acs, acu, upd, bwl, lg, pop;
  wire [7:0] taps;
  wire [7:0] dly;
  wire sync_pin = sync_oe ? sync_out : sync_src;
  int n_fail = 0, checked = 0, n_scr = 0, n_acs = 0, n_acu = 0, n_upd = 0, d, k;
  int ks[4] = '{2, 4, 5, 8};
  logic [2:0] modes[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};
  logic [6:0] ra[6] = '{7'h5C, 7'h5E, 7'h60, 7'h62, 7'h64, 7'h40};
  logic [15:0] rv[6] = '{16'h0000, 16'h0007, 16'h00C1, 16'h07D0, 16'h0000, 16'h0000};
  logic [15:0] exp_q[$];
  logic [15:0] rd_word;
  event rd_ev;
  iss_host_model host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
    .sync_src(sync_src));
  iss_top #(.GYRO_RANGE(2'h1), .INT_PERIOD(40), .ACC_PERIOD(20), .PULSE_CYC(16'h000C)) DUT (
    .clk(clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
    .sync_in(sync_pin), .sync_out(sync_out), .sync_oe(sync_oe), .data_valid_pin(dvp),
    .sample_clock_rate(scr), .accel_sample(acs), .accel_update(acu), .output_update(upd),
    .filt_taps(taps), .filt_delay(dly), .lin_g_comp_en(lg), .pop_align_en(pop),
    .bw_limit_en(bwl));
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    n_scr += scr;
    n_acs += acs;
    n_acu += acu;
    n_upd += upd;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic close_out();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cmp_val(input string what, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cmp_cnt(input string what, input int e, input int g);
    checked++;
    if (g != e) begin
      n_fail++;
      $display("mismatch %s expected %0d seen %0d", what, e, g);
    end
  endtask
  task automatic wr16(input logic [6:0] a, input logic [15:0] v);
    logic [15:0] r;
    host.xfer({1'b1, a, v[7:0]}, r);
    host.xfer({1'b1, a + 7'h01, v[15:8]}, r);
  endtask
  task automatic rd16(input logic [6:0] a, input logic [15:0] e);
    logic [15:0] r;
    exp_q.push_back(e);
    host.xfer({1'b0, a, 8'h00}, r);
    host.xfer(16'h0000, r);
    rd_word = r;
    -> rd_ev;
  endtask
  initial forever begin
    @(rd_ev);
    cmp_val("read word", exp_q.pop_front(), rd_word);
  end
  task automatic win(input int n);
    @(negedge clk);
    n_scr = 0;
    n_acs = 0;
    n_acu = 0;
    n_upd = 0;
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wait_upd();
    int i;
    for (i = 0; i < 2000 && upd !== 1'b1; i++) @(negedge clk);
    if (i == 2000) begin
      n_fail++;
      close_out();
    end
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    close_out();
  end
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (ra[i]) rd16(ra[i], rv[i]);
    cmp_val("lin g", {15'h0000, lg}, 16'h0001);
    cmp_val("percussion", {15'h0000, pop}, 16'h0001);
    wr16(`ISS_ADDR_RANGE, 16'h0000);
    rd16(`ISS_ADDR_RANGE, 16'h0007);
    for (int b = 0; b < 8; b++) begin
      wr16(`ISS_ADDR_FILT, 16'(b));
      @(negedge clk);
      cmp_val("taps", {8'h00, taps}, 16'h0001 << b);
      cmp_val("delay", {8'h00, dly}, 16'h0001 << b);
    end
    wr16(`ISS_ADDR_MSC, 16'h0001);
    rd16(`ISS_ADDR_MSC, 16'h0001);
    cmp_val("lin g", {15'h0000, lg}, 16'h0000);
    cmp_val("percussion", {15'h0000, pop}, 16'h0000);
    d = int'(rnd() % 4);
    wr16(`ISS_ADDR_DEC, 16'hF800 | 16'(d));
    rd16(`ISS_ADDR_DEC, 16'(d));
    win(400 * (d + 1));
    cmp_cnt("outputs", 10, n_upd);
    cmp_cnt("samples", 10 * (d + 1), n_scr);
    cmp_cnt("accel samples", 20 * (d + 1), n_acs);
    for (int p = 0; p < 2; p++) begin
      wr16(`ISS_ADDR_MSC, 16'(p));
      wait_upd();
      @(negedge clk);
      cmp_val("ready active", {15'h0000, dvp}, 16'(p));
      repeat (15) @(negedge clk);
      cmp_val("ready idle", {15'h0000, dvp}, 16'(1 - p));
    end
    foreach (modes[i]) begin
      wr16(`ISS_ADDR_MSC, {11'h000, modes[i], 2'h3});
      @(negedge clk);
      cmp_val("sync drive", {15'h0000, sync_oe}, 16'(modes[i] == `ISS_MODE_OUTSYNC));
      cmp_val("band limit", {15'h0000, bwl}, 16'(modes[i] == `ISS_MODE_PULSE));
      repeat (200) @(posedge clk);
    end
    wr16(`ISS_ADDR_DEC, 16'h0000);
    host.hi_cyc = 100;
    host.lo_cyc = 100;
    wr16(`ISS_ADDR_MSC, {11'h000, `ISS_MODE_DIRECT, 2'h3});
    win(2000);
    cmp_cnt("direct samples", 10, n_scr);
    cmp_cnt("direct accel", 20, n_acs);
    cmp_cnt("direct pairs", 10, n_acu);
    host.hi_cyc = 3;
    host.lo_cyc = 197;
    wr16(`ISS_ADDR_MSC, {11'h000, `ISS_MODE_PULSE, 2'h3});
    win(2000);
    cmp_cnt("pulse samples", 10, n_scr);
    cmp_cnt("pulse accel", 10, n_acs);
    k = ks[rnd() % 4];
    wr16(`ISS_ADDR_SCALE, 16'(k));
    host.hi_cyc = 200;
    host.lo_cyc = 200;
    wr16(`ISS_ADDR_MSC, {11'h000, `ISS_MODE_SCALED, 2'h3});
    repeat (1000) @(posedge clk);
    win(4000);
    cmp_cnt("scaled samples", 10 * k, n_scr);
    cmp_cnt("scaled outputs", 10 * k, n_upd);
    close_out();
  end
endmodule
